// ### hw/bmu_pkg.sv
// Package for the bit manipulation unit: operation codes, widths, field
// positions and reset values. Used by the shifter and the unit; the field file does not use it.
package bmu_pkg;
    localparam int ACC_W = 36;
    localparam int HALF_W = 16;
    localparam int SIGN_BIT = 35;
    localparam int MATH_OVF_LO = 31;
    localparam int NORM_REF_BIT = 31;
    localparam int LOGIC_SHIFT_W = 32;
    localparam int ALF_FLAG_LO = 4;
    localparam int ALF_FLAG_HI = 7;
    localparam int FIELD_WIDTH_LO = 8;
    localparam int FIELD_OFFSET_LO = 0;
    localparam int NUM_AUX = 4;
    localparam logic [35:0] ACC_RESET = 36'h000000000;
    localparam logic [15:0] AUX_RESET = 16'h0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // Operation selector from the sequencer
    typedef enum logic [3:0] {
        BMU_NOP,
        BMU_ASR,
        BMU_LSR,
        BMU_ASL,
        BMU_LSL,
        BMU_EXP,
        BMU_NORM,
        BMU_EXTS,
        BMU_EXTZ,
        BMU_INS,
        BMU_SHUF
    } bmu_op_t;

    // Where the shift amount or field spec comes from
    typedef enum logic [1:0] {
        SRC_IMM,
        SRC_AUX,
        SRC_ACC
    } bmu_src_t;
endpackage : bmu_pkg

// ### hw/bmu_shifter.sv
// Barrel shifter for the four shift kinds.
// Assumes the amount is already a signed 16-bit count; negative reverses.
`timescale 1ns/1ps
module bmu_shifter (
    input wire logic [35:0] din,        // Source accumulator
    input wire logic [15:0] amount,     // Signed shift count
    input wire bmu_pkg::bmu_op_t op,    // Shift kind
    output logic [35:0] dout,           // Shifted value
    output logic bad_amount             // Count out of range
);
    logic [6:0] mag;
    logic neg;

    // Magnitude of the count, saturated so huge counts flush fully
    always_comb begin
        neg = amount[15];
        if (neg) begin
            mag = (-amount > 16'd36) ? 7'd36 : 7'((-amount));
        end else begin
            mag = (amount > 16'd36) ? 7'd36 : amount[6:0];
        end
        bad_amount = (mag > 7'd35) && (op != bmu_pkg::BMU_NOP);
    end

    // Shift proper; a negative count runs the opposite direction
    always_comb begin
        dout = din;
        unique case (op)
            bmu_pkg::BMU_ASR: dout = neg ? (din << mag) : 36'($signed(din) >>> mag);
            bmu_pkg::BMU_LSR: dout = neg ? (din << mag) : {4'h0, din[31:0] >> mag};
            bmu_pkg::BMU_ASL: dout = neg ? 36'($signed(din) >>> mag) : (din << mag);
            bmu_pkg::BMU_LSL: dout = neg ? (din >> mag) : (din << mag);
            default: dout = din;
        endcase
    end
endmodule : bmu_shifter

// ### hw/bmu_field.sv
// Bit field extraction and insertion.
// Assumes spec upper byte is width, lower byte is offset from bit 0.
`timescale 1ns/1ps
module bmu_field (
    input wire logic [35:0] src,        // Source accumulator
    input wire logic [35:0] dst,        // Destination before insertion
    input wire logic [15:0] spec,       // Width and offset
    output logic [35:0] ext_s,          // Sign-extended extract
    output logic [35:0] ext_z,          // Zero-extended extract
    output logic [35:0] ins,            // Insert result
    output logic bad_field              // Width or offset illegal
);
    logic [7:0] width;
    logic [7:0] offset;
    logic [35:0] mask;
    logic [35:0] raw;

    // Decode the field and build a right-aligned mask
    always_comb begin
        width = spec[15:8];
        offset = spec[7:0];
        bad_field = (width == 8'h00) || (width > 8'h24) || (offset > 8'h23) ||
                    ({1'b0, width} + {1'b0, offset} > 9'h024);
        mask = bad_field ? 36'h000000000 : ~(36'hfffffffff << width[5:0]);
        raw = (src >> offset[5:0]) & mask;
        ext_z = raw;
        ext_s = raw | ((bad_field || !raw[width[5:0] - 6'd1]) ? 36'h000000000 : ~mask);
        ins = (dst & ~(mask << offset[5:0])) | ((src & mask) << offset[5:0]);
    end
endmodule : bmu_field

// ### hw/bmu_unit.sv
// Bit manipulation unit: shifts, exponent, normalize, field ops, shuffle.
// Behaviour
// - Holds four aux regs, two spares, four flags
// - Unit flags readable/writable at flag bits 4-7
// - Negative flag equals result bit 35
// - Zero flag when result bits all zero
// - Logical overflow on 36-bit overflow or bad field
// - Math overflow when bits 31-35 differ
// - Arithmetic right shift 36-bit, sign fill
// - Logical right shift 32-bit, zero fill
// - Arithmetic left shift into guard bits
// - Logical left shift 36-bit, zero fill
// - Immediate two cycles, aux one, accumulator two
// - Exponent writes redundant sign bit count
// - Normalize to bit 31, exponent into aux
// - Extract right-aligned, sign or zero extended
// - Insert field, always two cycles
// - Width upper byte, offset lower byte
// - Shuffle swaps source, spare, destination in one cycle
// - Parity flags follow latest result
// - Minus-one flags follow latest result
// Assumes the sequencer holds START for one cycle and keeps operands stable
// until DONE; accumulators live here, and the two working ones are visible on ports.
`timescale 1ns/1ps
module bmu_unit (
    input wire logic SYS_CLK,                   // 125 MHz core clock
    input wire logic RESET_N,                   // Synchronous reset, active low
    input wire logic START,                     // Begin an operation
    input wire bmu_pkg::bmu_op_t OP,            // Operation code
    input wire bmu_pkg::bmu_src_t SRC,          // Amount or field source
    input wire logic SRC_ACC_SEL,               // Source accumulator select
    input wire logic DST_ACC_SEL,               // Destination accumulator select
    input wire logic [1:0] AUX_SEL,             // Auxiliary register index
    input wire logic SPARE_SEL,                 // Spare accumulator index
    input wire logic [15:0] WIDE_IMMEDIATE,     // 16-bit immediate word
    input wire logic ACC_WR,                    // Load a working accumulator
    input wire logic ACC_WR_SEL,                // Which accumulator to load
    input wire logic [35:0] ACC_WR_DATA,        // Load value
    input wire logic AUX_WR,                    // Load an auxiliary register
    input wire logic [15:0] AUX_WR_DATA,        // Auxiliary load value
    input wire logic FLAG_WR,                   // Write unit flags
    input wire logic [7:0] FLAG_WR_DATA,        // Flag byte, bits 4-7 used
    output logic BUSY,                          // Operation in progress
    output logic DONE,                          // Result written on the edge before this cycle
    output logic [35:0] ACC0,                   // Working accumulator 0
    output logic [35:0] ACC1,                   // Working accumulator 1
    output logic [7:0] FLAG_RD_DATA,            // Flag byte, bits 4-7 valid
    output logic NEGATIVE_FLAG,                 // Result negative
    output logic ZERO_FLAG,                     // Result zero
    output logic LOGICAL_OVERFLOW_FLAG,         // 36-bit or field overflow
    output logic MATH_OVERFLOW_FLAG             // 32-bit overflow
);
    typedef enum logic [1:0] {BMU_IDLE, BMU_WAIT, BMU_FINISH} bmu_state_t;

    bmu_state_t state_q;
    logic [35:0] acc_q [2];
    logic [35:0] spare_acc_q [2];
    logic [15:0] aux_operand_regs_q [bmu_pkg::NUM_AUX];
    logic [3:0] unit_flags_q;
    logic neg_q, zero_q, lov_q, mov_q;
    logic [35:0] source_acc;
    logic [35:0] dst_old;
    logic [15:0] operand;
    logic [35:0] sh_out, ext_s, ext_z, ins_out;
    logic bad_amount, bad_field;
    logic [35:0] result;
    logic [15:0] norm_exp;
    logic [5:0] sign_run;
    logic lov_d, finish, two_cycle, asl_lost;

    // Operand selection
    always_comb begin
        source_acc = acc_q[SRC_ACC_SEL];
        dst_old = acc_q[DST_ACC_SEL];
        unique case (SRC)
            bmu_pkg::SRC_AUX: operand = aux_operand_regs_q[AUX_SEL];
            bmu_pkg::SRC_ACC: operand = acc_q[~SRC_ACC_SEL][31:16];
            default: operand = WIDE_IMMEDIATE;
        endcase
    end

    bmu_shifter u_shift (
        .din(source_acc),
        .amount(operand),
        .op(OP),
        .dout(sh_out),
        .bad_amount(bad_amount)
    );

    bmu_field u_field (
        .src(source_acc),
        .dst(dst_old),
        .spec(operand),
        .ext_s(ext_s),
        .ext_z(ext_z),
        .ins(ins_out),
        .bad_field(bad_field)
    );

    // Count redundant sign bits below bit 35
    always_comb begin
        sign_run = 6'd0;
        for (int i = bmu_pkg::SIGN_BIT - 1; i >= 0; i--) begin
            if (source_acc[i] == source_acc[bmu_pkg::SIGN_BIT] && sign_run == 6'(bmu_pkg::SIGN_BIT - 1 - i)) begin
                sign_run = sign_run + 6'd1;
            end
        end
    end

    // Normalize exponent relative to bit 31; may be negative when guard bits used
    assign norm_exp = 16'(signed'({10'h000, sign_run}) - 16'sd4);

    // Arithmetic left shift overflows when a bit pushed past bit 35 differs from the new sign;
    // shifting back and comparing catches every lost bit without a per-count table
    always_comb begin
        asl_lost = 1'b0;
        if (OP == bmu_pkg::BMU_ASL && !operand[15] && !bad_amount) begin
            asl_lost = (36'($signed(sh_out) >>> operand[5:0]) != source_acc);
        end
    end

    // Result multiplexer
    always_comb begin
        lov_d = 1'b0;
        unique case (OP)
            bmu_pkg::BMU_ASR, bmu_pkg::BMU_LSR, bmu_pkg::BMU_ASL, bmu_pkg::BMU_LSL: begin
                result = sh_out;
                lov_d = bad_amount || asl_lost;
            end
            bmu_pkg::BMU_EXP: result = {30'h00000000, sign_run};
            bmu_pkg::BMU_NORM: result = norm_exp[15] ? 36'($signed(source_acc) >>> 4'(-norm_exp))
                                                     : (source_acc << norm_exp[5:0]);
            bmu_pkg::BMU_EXTS: begin
                result = ext_s;
                lov_d = bad_field;
            end
            bmu_pkg::BMU_EXTZ: begin
                result = ext_z;
                lov_d = bad_field;
            end
            bmu_pkg::BMU_INS: begin
                result = ins_out;
                lov_d = bad_field;
            end
            bmu_pkg::BMU_SHUF: result = spare_acc_q[SPARE_SEL];
            default: result = dst_old;
        endcase
    end

    // Cycle count per form; insert and accumulator-count shifts always take two
    assign two_cycle = (OP == bmu_pkg::BMU_INS) ||
                       ((SRC != bmu_pkg::SRC_AUX) && (OP inside {bmu_pkg::BMU_ASR, bmu_pkg::BMU_LSR,
                        bmu_pkg::BMU_ASL, bmu_pkg::BMU_LSL, bmu_pkg::BMU_EXTS, bmu_pkg::BMU_EXTZ}));

    // Sequencing state machine
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            state_q <= BMU_IDLE;
        end else begin
            unique case (state_q)
                BMU_IDLE: if (START && OP != bmu_pkg::BMU_NOP) begin
                    state_q <= two_cycle ? BMU_WAIT : BMU_FINISH;
                end
                BMU_WAIT: state_q <= BMU_FINISH;
                BMU_FINISH: state_q <= BMU_IDLE;
                default: state_q <= BMU_IDLE;
            endcase
        end
    end

    // Result commits on the cycle the operation ends
    assign finish = (state_q == BMU_WAIT) ||
                    (state_q == BMU_IDLE && START && OP != bmu_pkg::BMU_NOP && !two_cycle);

    // Working and spare accumulators
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            acc_q <= '{bmu_pkg::ACC_RESET, bmu_pkg::ACC_RESET};
            spare_acc_q <= '{bmu_pkg::ACC_RESET, bmu_pkg::ACC_RESET};
        end else if (finish) begin
            acc_q[DST_ACC_SEL] <= result;
            if (OP == bmu_pkg::BMU_SHUF) begin
                spare_acc_q[SPARE_SEL] <= source_acc;
            end
        end else if (ACC_WR) begin
            acc_q[ACC_WR_SEL] <= ACC_WR_DATA;
        end
    end

    // Auxiliary registers; normalize writes its exponent
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            for (int i = 0; i < bmu_pkg::NUM_AUX; i++) begin
                aux_operand_regs_q[i] <= bmu_pkg::AUX_RESET;
            end
        end else if (finish && OP == bmu_pkg::BMU_NORM) begin
            aux_operand_regs_q[AUX_SEL] <= norm_exp;
        end else if (AUX_WR) begin
            aux_operand_regs_q[AUX_SEL] <= AUX_WR_DATA;
        end
    end

    // Flags: unit flags {result_not_neg_one_flag, result_neg_one_flag, evenp, oddp} and status flags
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            unit_flags_q <= bmu_pkg::FLAGS_RESET;
            {neg_q, zero_q, lov_q, mov_q} <= 4'h0;
        end else if (finish) begin
            unit_flags_q <= {~&result, &result, ~^result, ^result};
            neg_q <= result[bmu_pkg::SIGN_BIT];
            zero_q <= (result == 36'h000000000);
            lov_q <= lov_d;
            mov_q <= !(&result[35:31] || ~|result[35:31]);
        end else if (FLAG_WR) begin
            unit_flags_q <= FLAG_WR_DATA[bmu_pkg::ALF_FLAG_HI:bmu_pkg::ALF_FLAG_LO];
        end
    end

    // Outputs
    assign BUSY = (state_q != BMU_IDLE);
    assign DONE = (state_q == BMU_FINISH);
    assign ACC0 = acc_q[0];
    assign ACC1 = acc_q[1];
    assign FLAG_RD_DATA = {unit_flags_q, 4'h0};
    assign NEGATIVE_FLAG = neg_q;
    assign ZERO_FLAG = zero_q;
    assign LOGICAL_OVERFLOW_FLAG = lov_q;
    assign MATH_OVERFLOW_FLAG = mov_q;

    AST_NEG_BIT35: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        DONE |-> NEGATIVE_FLAG == (DST_ACC_SEL ? ACC1[35] : ACC0[35])) else $error("negative flag wrong");
    AST_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish |=> ZERO_FLAG == ($past(result) == 36'h000000000)) else $error("zero flag wrong");
    AST_MOV: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish |=> MATH_OVERFLOW_FLAG == ($past(result[35:31]) != 5'h00 && $past(result[35:31]) != 5'h1f))
        else $error("math overflow wrong");
    AST_LOV: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish && (OP == bmu_pkg::BMU_EXTZ) && bad_field |=> LOGICAL_OVERFLOW_FLAG) else $error("field overflow missed");
    AST_TWO_CYC: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_q == BMU_IDLE && START && OP == bmu_pkg::BMU_INS |=> BUSY ##1 DONE) else $error("insert not two cycles");
    AST_ONE_CYC: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_q == BMU_IDLE && START && OP == bmu_pkg::BMU_EXP |=> DONE) else $error("exp not one cycle");
    AST_PARITY: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish |=> unit_flags_q[0] != unit_flags_q[1]) else $error("parity flags not complementary");
    AST_MINUS1: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish |=> unit_flags_q[2] == ($past(result) == 36'hfffffffff)) else $error("minus one flag wrong");
    AST_SHUF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish && OP == bmu_pkg::BMU_SHUF |=> spare_acc_q[$past(SPARE_SEL)] == $past(source_acc))
        else $error("shuffle lost source");

    // Shape of each result except ASL, EXTS and INS, checked the cycle after it commits
    AST_ASR_SIGN: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish && OP == bmu_pkg::BMU_ASR && !operand[15] |=>
        acc_q[$past(DST_ACC_SEL)][35] == $past(source_acc[35])) else $error("right shift lost sign");
    AST_LSR_TOP: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish && OP == bmu_pkg::BMU_LSR && !operand[15] |=>
        acc_q[$past(DST_ACC_SEL)][35:32] == 4'h0) else $error("logical right shift filled guard bits");
    AST_LSL_LOW: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish && OP == bmu_pkg::BMU_LSL && !operand[15] && operand != 16'h0000 |=>
        acc_q[$past(DST_ACC_SEL)][0] == 1'b0) else $error("left shift did not zero fill");
    AST_EXP_MAX: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish && OP == bmu_pkg::BMU_EXP |=>
        acc_q[$past(DST_ACC_SEL)] <= 36'h000000023) else $error("exponent out of range");
    AST_NORM_JUST: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish && OP == bmu_pkg::BMU_NORM && source_acc != 36'h000000000 && source_acc != 36'hfffffffff |=>
        acc_q[$past(DST_ACC_SEL)][31] != acc_q[$past(DST_ACC_SEL)][30]) else $error("normalize not justified");
    AST_EXTZ_TOP: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish && OP == bmu_pkg::BMU_EXTZ && !bad_field |=>
        (acc_q[$past(DST_ACC_SEL)] >> $past(operand[15:8])) == 36'h000000000) else $error("extract not zero filled");
    AST_SHUF_DST: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        finish && OP == bmu_pkg::BMU_SHUF |=>
        acc_q[$past(DST_ACC_SEL)] == $past(spare_acc_q[SPARE_SEL])) else $error("shuffle lost spare");

    // Cycle count per operand form
    AST_AUX_ONE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_q == BMU_IDLE && START && SRC == bmu_pkg::SRC_AUX && OP inside {bmu_pkg::BMU_ASR,
        bmu_pkg::BMU_LSR, bmu_pkg::BMU_ASL, bmu_pkg::BMU_LSL, bmu_pkg::BMU_EXTS, bmu_pkg::BMU_EXTZ} |=> DONE)
        else $error("aux form not one cycle");
    AST_IMM_TWO: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_q == BMU_IDLE && START && SRC != bmu_pkg::SRC_AUX && OP inside {bmu_pkg::BMU_ASR,
        bmu_pkg::BMU_LSR, bmu_pkg::BMU_ASL, bmu_pkg::BMU_LSL} |=> !DONE ##1 DONE)
        else $error("immediate shift not two cycles");

    // Between commits nothing moves except by an explicit load
    AST_FLAG_WR: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        FLAG_WR && !finish |=> FLAG_RD_DATA == {$past(FLAG_WR_DATA[7:4]), 4'h0}) else $error("flag write lost");
    AST_FLAG_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !finish && !FLAG_WR |=> $stable(FLAG_RD_DATA)) else $error("unit flags moved");
    AST_ACC_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !finish && !ACC_WR |=> $stable(ACC0) && $stable(ACC1)) else $error("accumulator moved");
    AST_STATUS_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !finish |=> $stable({NEGATIVE_FLAG, ZERO_FLAG, LOGICAL_OVERFLOW_FLAG, MATH_OVERFLOW_FLAG}))
        else $error("status flags moved");

    // Each aux register moves only on a load or a normalize that names it
    for (genvar g = 0; g < bmu_pkg::NUM_AUX; g++) begin : g_aux_hold
        AST_AUX_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
            !((finish && OP == bmu_pkg::BMU_NORM) || AUX_WR) || AUX_SEL != 2'(g) |=>
            $stable(aux_operand_regs_q[g])) else $error("aux register moved");
    end
endmodule : bmu_unit

// ### sim/bmu_seq_model.sv
// Stand-in for the instruction sequencer: one START pulse per request, then
// times the answer. Assumes the bench holds the operation fields from before
// the request until ack.
`timescale 1ns/1ps
module bmu_seq_model (
    input wire logic clk,       // Core clock
    input wire logic req,       // One-cycle request from the bench
    input wire logic done_in,   // Completion pulse from the unit
    output logic start,         // Start pulse to the unit
    output logic ack,           // Operation seen complete
    output logic [3:0] cycles   // Edges from start to seen completion
);
    logic waiting;

    // Idle at time zero so no request leaks out of reset
    initial begin
        start = 1'b0;
        ack = 1'b0;
        cycles = 4'h0;
        waiting = 1'b0;
    end

    // Start lasts one cycle only; a held start would be a second request once busy falls
    always @(posedge clk) begin
        start <= req && !waiting;
        ack <= waiting && done_in;
        if (req && !waiting) begin
            waiting <= 1'b1;
            cycles <= 4'h0;
        end else if (waiting) begin
            cycles <= cycles + 4'h1;
            if (done_in) begin
                waiting <= 1'b0;
            end
        end
    end
endmodule : bmu_seq_model

// ### sim/bmu_unit_bench.sv
// Self-checking bench for the bit manipulation unit: table of operations, then
// spare, flag write, illegal field and idle reset cases.
// Assumes the sequencer model in bmu_seq_model and the package bmu_pkg.
`timescale 1ns/1ps
module bmu_unit_bench;
    typedef struct {
        bmu_pkg::bmu_op_t op;
        bmu_pkg::bmu_src_t src;
        logic [15:0] w;
        logic [35:0] a;
        logic [35:0] b;
        logic [35:0] r;
        logic [3:0] cyc;
        logic [7:0] flg;
    } bmu_row_t;
    logic sys_clk = 1'b0, reset_n = 1'b0, start, busy, done, req = 1'b0, ack;
    bmu_pkg::bmu_op_t op = bmu_pkg::BMU_NOP;
    bmu_pkg::bmu_src_t src = bmu_pkg::SRC_IMM;
    logic spare_sel = 1'b0, acc_wr = 1'b0, acc_wr_sel = 1'b0, aux_wr = 1'b0, flag_wr = 1'b0;
    logic src_sel = 1'b0, dst_sel = 1'b1;
    logic [1:0] aux_sel = 2'h1;
    logic [15:0] imm = 16'h0000, aux_data = 16'h0000;
    logic [35:0] acc_data = 36'h000000000, acc0, acc1;
    logic [7:0] flag_data = 8'h00, flag_rd;
    logic neg, zero, lov, mov;
    logic [3:0] cycles;
    int n_errors = 0, total_checks = 0;
    bmu_row_t rows[12];

    // Core clock, 8 ns period
    always #4 sys_clk = ~sys_clk;

    bmu_unit u_bmu_unit (.SYS_CLK(sys_clk), .RESET_N(reset_n), .START(start), .OP(op), .SRC(src),
        .SRC_ACC_SEL(src_sel), .DST_ACC_SEL(dst_sel), .AUX_SEL(aux_sel), .SPARE_SEL(spare_sel),
        .WIDE_IMMEDIATE(imm), .ACC_WR(acc_wr), .ACC_WR_SEL(acc_wr_sel), .ACC_WR_DATA(acc_data),
        .AUX_WR(aux_wr), .AUX_WR_DATA(aux_data), .FLAG_WR(flag_wr), .FLAG_WR_DATA(flag_data),
        .BUSY(busy), .DONE(done), .ACC0(acc0), .ACC1(acc1), .FLAG_RD_DATA(flag_rd),
        .NEGATIVE_FLAG(neg), .ZERO_FLAG(zero), .LOGICAL_OVERFLOW_FLAG(lov), .MATH_OVERFLOW_FLAG(mov));

    bmu_seq_model u_bmu_seq_model (.clk(sys_clk), .req(req), .done_in(done), .start(start), .ack(ack),
        .cycles(cycles));

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // Loads are one-cycle strobes, never given on an operation's finishing cycle
    task automatic ld(input logic sel, input logic [35:0] d, input logic [15:0] w);
        acc_wr <= 1'b1;
        acc_wr_sel <= sel;
        acc_data <= d;
        aux_wr <= 1'b1;
        aux_data <= w;
        imm <= w;
        @(posedge sys_clk);
        acc_wr <= 1'b0;
        aux_wr <= 1'b0;
        @(posedge sys_clk); // An edge between loads, so strobes are never reassigned in one step
    endtask : ld

    task automatic run(input bmu_pkg::bmu_op_t o, input bmu_pkg::bmu_src_t s);
        op <= o;
        src <= s;
        req <= 1'b1;
        @(posedge sys_clk);
        req <= 1'b0;
        for (int i = 0; i < 20 && ack !== 1'b1; i++)
            @(posedge sys_clk);
    endtask : run

    // Watchdog cut-off, well past the roughly 150 cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        test_done();
    end

    // Main sequence
    initial begin
        rows = '{
            '{bmu_pkg::BMU_ASR, bmu_pkg::SRC_AUX, 16'h0004, 36'h800000000, 36'h0, 36'hf80000000, 4'h2, 8'h90},
            '{bmu_pkg::BMU_LSR, bmu_pkg::SRC_IMM, 16'h0004, 36'h080000000, 36'h0, 36'h008000000, 4'h3, 8'h90},
            '{bmu_pkg::BMU_ASL, bmu_pkg::SRC_ACC, 16'h0000, 36'h040000001, 36'h30000, 36'h200000008, 4'h3, 8'ha0},
            '{bmu_pkg::BMU_LSL, bmu_pkg::SRC_AUX, 16'h0004, 36'h123456789, 36'h0, 36'h234567890, 4'h2, 8'ha0},
            '{bmu_pkg::BMU_EXP, bmu_pkg::SRC_AUX, 16'h0000, 36'h00000ffff, 36'h0, 36'h000000013, 4'h2, 8'h90},
            '{bmu_pkg::BMU_NORM, bmu_pkg::SRC_AUX, 16'h0000, 36'h00000ffff, 36'h0, 36'h07fff8000, 4'h2, 8'ha0},
            '{bmu_pkg::BMU_EXTS, bmu_pkg::SRC_AUX, 16'h0804, 36'h000000f80, 36'h0, 36'hffffffff8, 4'h2, 8'h90},
            '{bmu_pkg::BMU_EXTZ, bmu_pkg::SRC_IMM, 16'h0804, 36'h000000f80, 36'h0, 36'h0000000f8, 4'h3, 8'h90},
            '{bmu_pkg::BMU_INS, bmu_pkg::SRC_AUX, 16'h0408, 36'h00000000a, 36'h0, 36'h000000a00, 4'h3, 8'ha0},
            '{bmu_pkg::BMU_EXTS, bmu_pkg::SRC_IMM, 16'h0400, 36'h00000000f, 36'h0, 36'hfffffffff, 4'h3, 8'h60},
            '{bmu_pkg::BMU_SHUF, bmu_pkg::SRC_AUX, 16'h0000, 36'h555555555, 36'h0, 36'h000000000, 4'h2, 8'ha0},
            '{bmu_pkg::BMU_SHUF, bmu_pkg::SRC_AUX, 16'h0000, 36'h000000001, 36'h0, 36'h555555555, 4'h2, 8'ha0}};
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        // Each row: load operands, run, compare result, timing and all flags
        foreach (rows[i]) begin
            ld(1'b0, rows[i].a, rows[i].w);
            ld(1'b1, rows[i].b, rows[i].w);
            run(rows[i].op, rows[i].src);
            check(acc1, rows[i].r);
            check(cycles, rows[i].cyc);
            check(flag_rd, rows[i].flg);
            check({neg, zero}, {rows[i].r[35], rows[i].r == 36'h0});
            check(mov, !(&rows[i].r[35:31] || ~|rows[i].r[35:31]));
            check(lov, 1'b0);
        end
        // Overflowing arithmetic left shift, run from accumulator 1 into accumulator 0
        src_sel <= 1'b1;
        dst_sel <= 1'b0;
        ld(1'b1, 36'h400000001, 16'h0002);
        run(bmu_pkg::BMU_ASL, bmu_pkg::SRC_AUX);
        check(acc0, 36'h000000004);
        check(lov, 1'b1);
        src_sel <= 1'b0;
        dst_sel <= 1'b1;
        // Second spare is separate from the first, which now holds a value
        spare_sel <= 1'b1;
        ld(1'b0, 36'h000000001, 16'h0000);
        run(bmu_pkg::BMU_SHUF, bmu_pkg::SRC_AUX);
        check(acc1, 36'h0);
        check(lov, 1'b0);
        // Software write of the unit flags uses only the upper nibble
        flag_wr <= 1'b1;
        flag_data <= 8'h5f;
        @(posedge sys_clk);
        flag_wr <= 1'b0;
        @(posedge sys_clk);
        check(flag_rd, 8'h50);
        // Zero field width is illegal and must raise logical overflow
        ld(1'b1, 36'h000000123, 16'h0000);
        ld(1'b0, 36'h0000000ff, 16'h0000);
        run(bmu_pkg::BMU_EXTZ, bmu_pkg::SRC_AUX);
        check(lov, 1'b1);
        check(acc1, 36'h0);
        // Reset with the unit idle, after the last operation, clears accumulators and all flags
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        check(acc0, 36'h0);
        check(acc1, 36'h0);
        check({flag_rd, neg, zero, lov, mov, busy, done}, 14'h0);
        test_done();
    end
endmodule : bmu_unit_bench
